//--- hpr_pkg.sv
// Package: host port register map, field layout and carriers
package hpr_pkg;

  // Host-side byte addresses (3-bit host address bus)
  localparam logic [2:0] HPR_ADDR_HIC   = 3'h0;
  localparam logic [2:0] HPR_ADDR_CMV   = 3'h1;
  localparam logic [2:0] HPR_ADDR_ISR   = 3'h2;
  localparam logic [2:0] HPR_ADDR_IVN   = 3'h3;
  localparam logic [2:0] HPR_ADDR_TXU   = 3'h4;
  localparam logic [2:0] HPR_ADDR_TXH   = 3'h5;
  localparam logic [2:0] HPR_ADDR_TXM   = 3'h6;
  localparam logic [2:0] HPR_ADDR_TXL   = 3'h7;

  // Interrupt control register field positions
  localparam int HPR_HIC_RREQ  = 0;
  localparam int HPR_HIC_TREQ  = 1;
  localparam int HPR_HIC_DRQS  = 2;
  localparam int HPR_HIC_HF0   = 3;
  localparam int HPR_HIC_HF1   = 4;
  localparam int HPR_HIC_BORD  = 5;
  localparam int HPR_HIC_INIT  = 7;

  // Command vector field layout
  localparam int HPR_CMV_PEND  = 7;
  localparam int HPR_CMV_VEC_W = 7;

  // Status register bit positions
  localparam int HPR_ISR_RXDF  = 0;
  localparam int HPR_ISR_TXDE  = 1;
  localparam int HPR_ISR_TRDY  = 2;

  // Reset values
  localparam logic [7:0] HPR_HIC_RESET = 8'h00;
  localparam logic [7:0] HPR_CMV_RESET = 8'h32;
  localparam logic [7:0] HPR_IVN_RESET = 8'h0F;
  localparam logic [7:0] HPR_UNUSED_BYTE = 8'h00;

  // Word geometry
  localparam int HPR_WORD_W    = 24;
  localparam int HPR_FIFO_D    = 8;

  // Host bus access
  typedef struct packed {
    logic       cs;
    logic       rd;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } hpr_host_req_t;

  // Request pin pair: output levels
  typedef struct packed {
    logic req_a;
    logic req_b;
  } hpr_req_pins_t;

  // Host command handed to the processor core
  typedef struct packed {
    logic                  valid;
    logic [HPR_CMV_VEC_W:0] addr;
  } hpr_cmd_t;

endpackage

//--- hpr_fifo.sv
// Synchronous valid/ready FIFO held in flip-flops
`timescale 1ns/1ps
module hpr_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             flush_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wptr_reg;
  logic [AW-1:0]    rptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // Handshake terms
  assign in_ready_o  = (count_reg != DEPTH[AW:0]);
  assign out_valid_o = (count_reg != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem_reg[rptr_reg];

  // Storage write
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_reg[wptr_reg] <= in_data_i;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      count_reg <= '0;
    end else if (flush_i) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= (wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= (rptr_reg == AW'(DEPTH - 1)) ? '0 : rptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

//--- hpr_cmd_sync.sv
// Host command handshake: pending bit and doubled vector address
`timescale 1ns/1ps
module hpr_cmd_sync (
  // Clock and reset
  input  wire logic               sys_clk_i,
  input  wire logic               resetn_i,
  // Host write to the command vector
  input  wire logic               wr_i,
  input  wire logic [7:0]         wdata_i,
  // Core acceptance of the command interrupt
  input  wire logic               core_ack_i,
  // State
  output logic [7:0]              cmv_o,
  output hpr_pkg::hpr_cmd_t       cmd_o
);
  import hpr_pkg::*;

  logic [7:0] cmv_reg;
  logic       pend_next;

  // Set by host wins over the clear by the core
  always_comb begin
    pend_next = cmv_reg[HPR_CMV_PEND];
    if (core_ack_i) begin
      pend_next = 1'b0;
    end
    if (wr_i && wdata_i[HPR_CMV_PEND]) begin
      pend_next = 1'b1;
    end
  end

  // Vector field held while a command waits
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmv_reg <= HPR_CMV_RESET;
    end else begin
      if (wr_i && !cmv_reg[HPR_CMV_PEND]) begin
        cmv_reg[HPR_CMV_VEC_W-1:0] <= wdata_i[HPR_CMV_VEC_W-1:0];
      end
      cmv_reg[HPR_CMV_PEND] <= pend_next;
    end
  end

  assign cmv_o       = cmv_reg;
  assign cmd_o.valid = cmv_reg[HPR_CMV_PEND];
  assign cmd_o.addr  = {cmv_reg[HPR_CMV_VEC_W-1:0], 1'b0};
endmodule

//--- hpr_top.sv
// Host-side register set of the 8-bit parallel host port
`timescale 1ns/1ps
// Operation
// - Receive enable: interrupt gate, or DMA direction
// - Transmit enable: interrupt gate, or DMA direction
// - Request pins: combined/ack or separate tx/rx
// - Host flag bits are write-only to host
// - Init bit write-only; one resets DMA state
// - Command address is vector field doubled
// - Command bit pending until core takes it
// - Word seen as low/middle/high; fourth byte zero
module hpr_top #(
  parameter int WORD_W = 24,
  parameter int DEPTH  = 8
) (
  // Clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  resetn_i,
  // Host bus
  input  wire hpr_pkg::hpr_host_req_t host_req_i,
  output logic [7:0]                 host_rdata_o,
  input  wire logic                  ack_in_i,
  // Request pins
  output hpr_pkg::hpr_req_pins_t     req_pins_o,
  // Processor side: transmit words
  input  wire logic                  core_tx_valid_i,
  output logic                       core_tx_ready_o,
  input  wire logic [WORD_W-1:0]     core_tx_data_i,
  // Processor side: receive words
  output logic                       core_rx_valid_o,
  input  wire logic                  core_rx_ready_i,
  output logic [WORD_W-1:0]          core_rx_data_o,
  // Processor side: control view
  output logic                       dma_mode_o,
  input  wire logic                  dma_en_i,
  output logic [1:0]                 host_flags_o,
  output logic                       dma_init_o,
  output hpr_pkg::hpr_cmd_t          cmd_o,
  input  wire logic                  cmd_ack_i,
  output logic [7:0]                 ivn_o
);
  import hpr_pkg::*;

  typedef enum logic [2:0] {
    HPR_ST_IDLE = 3'b001,
    HPR_ST_LOAD = 3'b010,
    HPR_ST_HOLD = 3'b100
  } hpr_tx_state_t;

  logic [7:0]        hic_reg;
  logic [7:0]        ivn_reg;
  logic [WORD_W-1:0] txw_reg;
  logic [WORD_W-1:0] rxw_reg;
  logic              rxw_full_reg;
  logic              init_reg;
  logic [7:0]        rdata_reg;
  hpr_tx_state_t     tx_state_reg;
  logic [7:0]        cmv_val;
  logic              wr_en;
  logic              rd_en;
  logic              fifo_valid;
  logic              fifo_ready;
  logic [WORD_W-1:0] fifo_data;
  logic              txde;
  logic              host_rx_irq;
  logic              host_tx_irq;
  logic              dma_h2p;
  logic              dma_p2h;
  logic              any_req;
  logic              bord;
  logic [1:0]        lane_w;

  assign wr_en = host_req_i.cs && host_req_i.wr;
  assign rd_en = host_req_i.cs && host_req_i.rd;
  assign bord  = hic_reg[HPR_HIC_BORD];

  // Map a data address to a byte lane, reversed when little-endian
  function automatic logic [1:0] lane_of(input logic [2:0] a, input logic rev);
    logic [1:0] l;
    begin
      l = 2'h3 - a[1:0]; // low=0 mid=1 high=2 unused=3
      if (rev && l != 2'h3) begin
        l = 2'h2 - l;
      end
      return l;
    end
  endfunction

  // Transmit word from the processor is buffered
  hpr_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .resetn_i    (resetn_i),
    .flush_i     (init_reg),
    .in_valid_i  (core_tx_valid_i),
    .in_ready_o  (core_tx_ready_o),
    .in_data_i   (core_tx_data_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_ready),
    .out_data_o  (fifo_data)
  );

  // Command vector handshake
  hpr_cmd_sync u_cmd (
    .sys_clk_i  (sys_clk_i),
    .resetn_i   (resetn_i),
    .wr_i       (wr_en && host_req_i.addr == HPR_ADDR_CMV),
    .wdata_i    (host_req_i.wdata),
    .core_ack_i (cmd_ack_i),
    .cmv_o      (cmv_val),
    .cmd_o      (cmd_o)
  );

  // Interrupt control register; init bit never stored
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hic_reg <= HPR_HIC_RESET;
    end else if (wr_en && host_req_i.addr == HPR_ADDR_HIC) begin
      hic_reg <= {1'b0, 1'b0, host_req_i.wdata[5:0]};
    end
  end

  // Init pulse on writing one; zero does nothing
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      init_reg <= 1'b0;
    end else begin
      init_reg <= wr_en && host_req_i.addr == HPR_ADDR_HIC && host_req_i.wdata[HPR_HIC_INIT];
    end
  end

  // Interrupt vector register
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ivn_reg <= HPR_IVN_RESET;
    end else if (wr_en && host_req_i.addr == HPR_ADDR_IVN) begin
      ivn_reg <= host_req_i.wdata;
    end
  end

  // Transmit holding word fed from the FIFO
  assign fifo_ready = (tx_state_reg == HPR_ST_IDLE);
  assign txde       = (tx_state_reg != HPR_ST_HOLD);

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_state_reg <= HPR_ST_IDLE;
      txw_reg      <= '0;
    end else if (init_reg) begin
      tx_state_reg <= HPR_ST_IDLE;
    end else begin
      unique case (tx_state_reg)
        HPR_ST_IDLE: begin
          if (fifo_valid) begin
            txw_reg      <= fifo_data;
            tx_state_reg <= HPR_ST_LOAD;
          end
        end
        HPR_ST_LOAD: begin
          tx_state_reg <= HPR_ST_HOLD;
        end
        HPR_ST_HOLD: begin
          // Reading the last byte empties the word
          if (rd_en && host_req_i.addr == HPR_ADDR_TXL) begin
            tx_state_reg <= HPR_ST_IDLE;
          end
        end
      endcase
    end
  end

  // Receive word assembled from host byte writes
  assign lane_w = lane_of(host_req_i.addr, bord);

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rxw_reg      <= '0;
      rxw_full_reg <= 1'b0;
    end else if (init_reg) begin
      rxw_full_reg <= 1'b0;
    end else begin
      if (wr_en && host_req_i.addr[2] && lane_w != 2'h3) begin
        rxw_reg[lane_w*8 +: 8] <= host_req_i.wdata;
      end
      if (wr_en && host_req_i.addr == HPR_ADDR_TXL) begin
        rxw_full_reg <= 1'b1;
      end else if (core_rx_ready_i) begin
        rxw_full_reg <= 1'b0;
      end
    end
  end

  assign core_rx_valid_o = rxw_full_reg;
  assign core_rx_data_o  = rxw_reg;

  // Host read data; flags and init read as zero
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_reg <= 8'h00;
    end else if (rd_en) begin
      unique case (host_req_i.addr)
        HPR_ADDR_HIC: rdata_reg <= hic_reg & 8'h27;
        HPR_ADDR_CMV: rdata_reg <= cmv_val;
        HPR_ADDR_ISR: rdata_reg <= {5'h00, txde && !dma_en_i, txde, rxw_full_reg};
        HPR_ADDR_IVN: rdata_reg <= ivn_reg;
        HPR_ADDR_TXU: rdata_reg <= HPR_UNUSED_BYTE;
        default: begin
          rdata_reg <= txw_reg[lane_of(host_req_i.addr, bord)*8 +: 8];
        end
      endcase
    end
  end

  // Requests: interrupt gates or DMA direction
  assign host_rx_irq = !dma_en_i && hic_reg[HPR_HIC_RREQ] && !txde;
  assign host_tx_irq = !dma_en_i && hic_reg[HPR_HIC_TREQ] && !rxw_full_reg;
  assign dma_p2h     = dma_en_i && hic_reg[HPR_HIC_RREQ] && !txde;
  assign dma_h2p     = dma_en_i && hic_reg[HPR_HIC_TREQ] && !rxw_full_reg;
  assign any_req     = host_rx_irq || host_tx_irq || dma_p2h || dma_h2p;

  // Pin pair usage
  always_comb begin
    if (hic_reg[HPR_HIC_DRQS]) begin
      req_pins_o.req_a = host_tx_irq || dma_h2p;
      req_pins_o.req_b = host_rx_irq || dma_p2h;
    end else begin
      req_pins_o.req_a = any_req && !ack_in_i;
      req_pins_o.req_b = 1'b0;
    end
  end

  assign host_rdata_o = rdata_reg;
  assign dma_mode_o   = hic_reg[HPR_HIC_RREQ];
  assign host_flags_o = {hic_reg[HPR_HIC_HF1], hic_reg[HPR_HIC_HF0]};
  assign dma_init_o   = init_reg;
  assign ivn_o        = ivn_reg;
endmodule

//--- hpr_top_asserts.sv
// Checker: timing relations at the host port register set boundary
`timescale 1ns/1ps
module hpr_top_asserts #(
  parameter int WORD_W = 24,
  parameter int DEPTH  = 8
) (
  // Clock and reset
  input wire logic                   sys_clk_i,
  input wire logic                   resetn_i,
  // Host side
  input wire hpr_pkg::hpr_host_req_t host_req_i,
  input wire logic [7:0]             host_rdata_o,
  input wire hpr_pkg::hpr_req_pins_t req_pins_o,
  // Processor side
  input wire logic                   dma_en_i,
  input wire logic [1:0]             host_flags_o,
  input wire logic                   dma_init_o,
  input wire hpr_pkg::hpr_cmd_t      cmd_o,
  input wire logic                   cmd_ack_i
);
  import hpr_pkg::*;
  logic [2:0] hic_reg;
  logic       hic_wr;
  logic       cmv_set;

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  // Write decodes
  assign hic_wr  = host_req_i.cs && host_req_i.wr && host_req_i.addr == HPR_ADDR_HIC;
  assign cmv_set = host_req_i.cs && host_req_i.wr && host_req_i.addr == HPR_ADDR_CMV && host_req_i.wdata[7];

  // Shadow of the request control bits
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) hic_reg <= 3'h0;
    else if (hic_wr) hic_reg <= host_req_i.wdata[2:0];
  end

  // Next-cycle and same-cycle behaviours
  sequence s_hic_rd;
    host_req_i.cs && host_req_i.rd && host_req_i.addr == HPR_ADDR_HIC;
  endsequence
  sequence s_unused_rd;
    host_req_i.cs && host_req_i.rd && host_req_i.addr == HPR_ADDR_TXU;
  endsequence
  sequence s_cmd_new;
    cmv_set && !cmd_o.valid;
  endsequence

  property p_init;
    hic_wr && host_req_i.wdata[7] |=> dma_init_o;
  endproperty
  property p_init_src;
    dma_init_o |-> $past(hic_wr && host_req_i.wdata[7]);
  endproperty
  property p_flags;
    hic_wr |=> host_flags_o == $past(host_req_i.wdata[4:3]);
  endproperty
  property p_hic_rd;
    s_hic_rd |=> host_rdata_o[7:6] == 2'h0 && host_rdata_o[4:3] == 2'h0;
  endproperty
  property p_unused;
    s_unused_rd |=> host_rdata_o == HPR_UNUSED_BYTE;
  endproperty
  property p_cmd_set;
    s_cmd_new |=> cmd_o.valid && cmd_o.addr == {$past(host_req_i.wdata[6:0]), 1'b0};
  endproperty
  property p_cmd_hold;
    cmd_o.valid && !cmd_ack_i |=> cmd_o.valid && $stable(cmd_o.addr);
  endproperty
  property p_cmd_clr;
    cmd_ack_i && !cmv_set |=> !cmd_o.valid;
  endproperty
  property p_req_off;
    !dma_en_i && hic_reg[1:0] == 2'h0 |-> !req_pins_o.req_a && !req_pins_o.req_b;
  endproperty
  property p_req_b;
    hic_reg[2] == 1'b0 |-> !req_pins_o.req_b;
  endproperty

  a_init: assert property (p_init) else $error("init pulse missing");
  a_init_src: assert property (p_init_src) else $error("init pulse without cause");
  a_flags: assert property (p_flags) else $error("host flags not passed on");
  a_hic_rd: assert property (p_hic_rd) else $error("write-only bits read back");
  a_unused: assert property (p_unused) else $error("unused byte not zero");
  a_cmd_set: assert property (p_cmd_set) else $error("command address wrong");
  a_cmd_hold: assert property (p_cmd_hold) else $error("command dropped early");
  a_cmd_clr: assert property (p_cmd_clr) else $error("command not cleared");
  a_req_off: assert property (p_req_off) else $error("request with enables off");
  a_req_b: assert property (p_req_b) else $error("second pin driven in combined mode");
endmodule

bind hpr_top hpr_top_asserts #(.WORD_W(WORD_W), .DEPTH(DEPTH)) u_chk (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .host_req_i(host_req_i), .host_rdata_o(host_rdata_o),
  .req_pins_o(req_pins_o), .dma_en_i(dma_en_i), .host_flags_o(host_flags_o), .dma_init_o(dma_init_o),
  .cmd_o(cmd_o), .cmd_ack_i(cmd_ack_i));

//--- hpr_host_model.sv
// Host processor model: byte-wide accesses on the host bus
`timescale 1ns/1ps
module hpr_host_model (
  // Clock
  input  wire logic              sys_clk_i,
  // Host bus
  output hpr_pkg::hpr_host_req_t host_req_o,
  input  wire logic [7:0]        host_rdata_i,
  output logic                   ack_o
);
  import hpr_pkg::*;

  // Idle bus at start
  initial begin
    host_req_o = '0;
    ack_o      = 1'b0;
  end

  // One access held through its taking edge, then released with lines flipped
  task automatic xfer(input logic r, input logic [2:0] a, input logic [7:0] wd, output logic [7:0] v);
    @(negedge sys_clk_i);
    host_req_o <= {1'b1, r, ~r, a, wd};
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    v = host_rdata_i;
    host_req_o <= {3'b000, ~a, ~wd};
  endtask

  // Write; flags and init are never read back
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] v;
    xfer(1'b0, a, d, v);
  endtask

  // Read one byte lane
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    xfer(1'b1, a, 8'h00, v);
  endtask

  // Acknowledge level
  task automatic set_ack(input logic b);
    @(negedge sys_clk_i);
    ack_o <= b;
  endtask
endmodule

//--- hpr_top_bench.sv
// Testbench: host port register set against a queue reference
`timescale 1ns/1ps
module hpr_top_bench;
  import hpr_pkg::*;
  logic          sys_clk_i = 1'b0;
  logic          resetn_i  = 1'b0;
  hpr_host_req_t host_req;
  hpr_req_pins_t pins;
  hpr_cmd_t      cmd;
  logic [7:0]    rdata, ivn, d;
  logic [1:0]    flags;
  logic [23:0]   tx_d = 24'h0, rx_d, w;
  logic          ack, tx_rdy, rx_v, dma_mode, init;
  logic          tx_v = 1'b0, rx_rdy = 1'b0, dma_en = 1'b0, cmd_ack = 1'b0;
  int            errors = 0, compares = 0, cyc = 0, seed = 95, n;
  logic [23:0]   q[$];

  always #25 sys_clk_i = ~sys_clk_i;

  hpr_host_model i_host (.sys_clk_i(sys_clk_i), .host_req_o(host_req), .host_rdata_i(rdata), .ack_o(ack));

  hpr_top #(.WORD_W(24), .DEPTH(HPR_FIFO_D)) i_dut (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .host_req_i(host_req), .host_rdata_o(rdata),
    .ack_in_i(ack), .req_pins_o(pins), .core_tx_valid_i(tx_v), .core_tx_ready_o(tx_rdy),
    .core_tx_data_i(tx_d), .core_rx_valid_o(rx_v), .core_rx_ready_i(rx_rdy), .core_rx_data_o(rx_d),
    .dma_mode_o(dma_mode), .dma_en_i(dma_en), .host_flags_o(flags), .dma_init_o(init),
    .cmd_o(cmd), .cmd_ack_i(cmd_ack), .ivn_o(ivn));

  // Verdict and end of run
  task automatic final_report;
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Read one register and compare
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    i_host.rd(a, v);
    chk(v, e);
  endtask

  // Request pins for one acknowledge level and control setting
  task automatic pin_chk(input logic a, input logic [7:0] c, input logic [1:0] e);
    i_host.set_ack(a);
    i_host.wr(HPR_ADDR_HIC, c);
    chk(pins, e);
  endtask

  // Hang guard
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
  end

  initial begin
    repeat (12) @(posedge sys_clk_i);
    @(negedge sys_clk_i) resetn_i = 1'b1;
    // Reset values
    rdc(HPR_ADDR_HIC, HPR_HIC_RESET);
    rdc(HPR_ADDR_CMV, HPR_CMV_RESET);
    rdc(HPR_ADDR_IVN, HPR_IVN_RESET);
    rdc(HPR_ADDR_TXU, HPR_UNUSED_BYTE);
    rdc(HPR_ADDR_ISR, 8'h06);
    chk(cmd, 9'h064);
    i_host.wr(HPR_ADDR_IVN, 8'hA5);
    rdc(HPR_ADDR_IVN, 8'hA5);
    chk(ivn, 8'hA5);
    // Control register, random settings
    repeat (6) begin
      d = $random(seed);
      d[7] = 1'b0;
      i_host.wr(HPR_ADDR_HIC, d);
      chk(flags, d[4:3]);
      chk(dma_mode, d[0]);
      rdc(HPR_ADDR_HIC, d & 8'h27);
    end
    i_host.wr(HPR_ADDR_HIC, 8'h80);
    chk(init, 1'b1);
    rdc(HPR_ADDR_HIC, 8'h00);
    // Command handshake; a second vector while pending is ignored
    d = $random(seed);
    d[7] = 1'b1;
    i_host.wr(HPR_ADDR_CMV, d);
    chk(cmd, {1'b1, d[6:0], 1'b0});
    i_host.wr(HPR_ADDR_CMV, d ^ 8'h7F);
    chk(cmd, {1'b1, d[6:0], 1'b0});
    @(negedge sys_clk_i) cmd_ack = 1'b1;
    @(negedge sys_clk_i) cmd_ack = 1'b0;
    chk(cmd.valid, 1'b0);
    // Fill the transmit path until it refuses
    n = 0;
    repeat (20) begin
      @(negedge sys_clk_i);
      tx_v = 1'b1;
      // Ready is settled here; data changes only for a word the next edge takes
      if (tx_rdy) begin
        tx_d = $random(seed);
        q.push_back(tx_d);
        n++;
      end
    end
    @(negedge sys_clk_i) tx_v = 1'b0;
    chk(n, HPR_FIFO_D + 1);
    // Request pin roles
    pin_chk(1'b0, 8'h05, 2'b01);
    pin_chk(1'b0, 8'h06, 2'b10);
    pin_chk(1'b0, 8'h01, 2'b10);
    pin_chk(1'b1, 8'h01, 2'b00);
    pin_chk(1'b0, 8'h04, 2'b00);
    // Same pins with DMA on: direction requests
    @(negedge sys_clk_i) dma_en = 1'b1;
    pin_chk(1'b0, 8'h05, 2'b01);
    pin_chk(1'b0, 8'h06, 2'b10);
    @(negedge sys_clk_i) dma_en = 1'b0;
    // Drain words byte by byte, alternating byte order
    foreach (q[i]) begin
      w = q[i];
      i_host.wr(HPR_ADDR_HIC, {2'b00, i[0], 5'h00});
      if (i[0]) w = {w[7:0], w[15:8], w[23:16]};
      rdc(HPR_ADDR_TXH, w[23:16]);
      rdc(HPR_ADDR_TXM, w[15:8]);
      rdc(HPR_ADDR_TXL, w[7:0]);
      repeat (3) @(posedge sys_clk_i);
    end
    // Host-written word reaches the processor
    i_host.wr(HPR_ADDR_HIC, 8'h00);
    w = $random(seed);
    i_host.wr(HPR_ADDR_TXH, w[23:16]);
    i_host.wr(HPR_ADDR_TXM, w[15:8]);
    i_host.wr(HPR_ADDR_TXL, w[7:0]);
    chk({rx_v, rx_d}, {1'b1, w});
    @(negedge sys_clk_i) rx_rdy = 1'b1;
    @(negedge sys_clk_i) rx_rdy = 1'b0;
    chk(rx_v, 1'b0);
    final_report();
  end
endmodule
